// ===== mci_pkg.sv
// Package with constants and carrier types for the instruction subset core block.
// Summary of operation
// [RL1] Bit toggle 0111 bbba ffff ffff inverts one bit; flags untouched.
// [RL2] Access flag 0 picks access bank; 1 picks bank select register bank.
// [RL3] Flag 0, extended set on, address <= 95: indexed literal offset addressing.
// [RL4] Opcode 1110 0100 branches only when overflow is one; flags untouched.
// [RL5] Opcode 1110 0000 branches only when zero is one; flags untouched.
// [RL6] Taken branch: signed offset, target is incremented address plus twice offset.
// [RL7] Branch: one cycle untaken; taken writes PC in Q4, then idle cycle.
// [RL8] Call pushes address of following instruction, call address plus 4.
// [RL9] Call fast-save flag 1 copies working, status, bank select into shadows.
// [RL10] Call loads 20-bit target into PC bits 20..1; flags untouched.
// [RL11] Call words: 1110 110s k7..k0, then 1111 k19..k8.
// [RL12] Call takes two cycles: read, push, read high, write PC, then idle.
// [RL13] Clear 0110 101a ffff ffff writes zero and sets zero flag only.
// [RL14] Register ops: decode Q1, read Q2, compute Q3, write back Q4.
package mci_pkg;
  localparam int PC_W = 21;
  localparam int DA_W = 12;
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q3 = 2'h2;
  localparam logic [1:0] PH_Q4 = 2'h3;
  localparam logic [3:0] OPC_BIT_TOGGLE = 4'h7;
  localparam logic [6:0] OPC_CLEAR = 7'h35;
  localparam logic [7:0] OPC_BRANCH_OV = 8'he4;
  localparam logic [7:0] OPC_BRANCH_Z = 8'he0;
  localparam logic [6:0] OPC_CALL_FIRST = 7'h76;
  localparam logic [3:0] OPC_CALL_SECOND = 4'hf;
  localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
  localparam int ZERO_BIT = 0;
  localparam int OVF_BIT = 3;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BIT_ONE = 8'h01;

  typedef enum logic [2:0] {
    K_NONE,
    K_BIT_TOGGLE,
    K_CLEAR,
    K_BRANCH_OV,
    K_BRANCH_Z,
    K_CALL
  } mci_kind_e;

  typedef enum logic {
    ST_EXEC,
    ST_IDLE
  } mci_state_e;

  typedef struct packed {
    logic [DA_W-1:0] addr;
    logic [7:0] wdata;
  } mci_dm_req_s;

  typedef struct packed {
    logic [7:0] working;
    logic [7:0] flags;
    logic [3:0] bank;
  } mci_shadow_s;
endpackage : mci_pkg

// ===== mci_core.sv
// Decode and execute logic for bit toggle, two branches, subroutine call and register clear.
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module mci_core
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rstn,
  // Program memory fetch path.
  input wire logic [15:0] i_prog_word,
  output logic [mci_pkg::PC_W-1:0] o_prog_addr,
  output logic [mci_pkg::PC_W-1:0] o_pc,
  // Core state read from the datapath.
  input wire logic i_ext_set_en,
  input wire logic [mci_pkg::DA_W-1:0] i_index_base,
  input wire logic [3:0] i_bank_select_reg,
  input wire logic [7:0] i_working,
  input wire logic [7:0] i_status,
  // Data memory.
  input wire logic [7:0] i_dm_rdata,
  output logic o_dm_rd,
  output logic o_dm_wr,
  output mci_pkg::mci_dm_req_s o_dm,
  output logic o_zero_set,
  // Return stack and shadow registers.
  output logic o_push,
  output logic [mci_pkg::PC_W-1:0] o_return_stack_top,
  output logic o_shadow_save,
  output mci_pkg::mci_shadow_s o_shadow,
  // Phase of the instruction cycle.
  output logic [1:0] o_phase
);
  import mci_pkg::*;

  function automatic mci_kind_e decode_word(input logic [15:0] w);
    mci_kind_e k;
    k = K_NONE;
    if (w[15:12] == OPC_BIT_TOGGLE)
      k = K_BIT_TOGGLE; // [RL1]
    else if (w[15:9] == OPC_CLEAR)
      k = K_CLEAR; // [RL13]
    else if (w[15:8] == OPC_BRANCH_OV)
      k = K_BRANCH_OV; // [RL4]
    else if (w[15:8] == OPC_BRANCH_Z)
      k = K_BRANCH_Z; // [RL5]
    else if (w[15:9] == OPC_CALL_FIRST)
      k = K_CALL; // [RL11]
    return k;
  endfunction : decode_word

  // Effective data address; the bank bits come from the bank select register only when the access flag is 1.
  function automatic logic [DA_W-1:0] data_addr(input logic [15:0] w,
                                                input logic ext_en,
                                                input logic [DA_W-1:0] base,
                                                input logic [3:0] bank);
    logic [DA_W-1:0] a;
    a = {bank, w[7:0]}; // [RL2]
    if (!w[8])
    begin
      if (ext_en && w[7:0] <= INDEXED_LIMIT)
        a = base + {4'h0, w[7:0]}; // [RL3]
      else if (w[7:0] < ACCESS_SPLIT)
        a = {ACCESS_LO_BANK, w[7:0]}; // [RL2]
      else
        a = {ACCESS_HI_BANK, w[7:0]}; // [RL2]
    end
    return a;
  endfunction : data_addr

  logic [1:0] phase_reg, phase_next;
  mci_state_e state_reg, state_next;
  mci_kind_e kind_reg, kind_next;
  logic [15:0] ir_reg, ir_next;
  logic [PC_W-1:0] pc_reg, pc_next;
  logic [PC_W-1:0] prog_addr_reg, prog_addr_next;
  logic taken_reg, taken_next;
  logic call_ok_reg, call_ok_next;
  logic dm_rd_reg, dm_rd_next;
  logic dm_wr_reg, dm_wr_next;
  mci_dm_req_s dm_reg, dm_next;
  logic zero_set_reg, zero_set_next;
  logic push_reg, push_next;
  logic [PC_W-1:0] tos_reg, tos_next;
  logic shadow_save_reg, shadow_save_next;
  mci_shadow_s shadow_reg, shadow_next;
  logic [PC_W-1:0] branch_disp;

  // Offset doubled and sign extended to the program counter width.
  assign branch_disp = {{(PC_W-9){ir_reg[7]}}, ir_reg[7:0], 1'b0}; // [RL6]

  always_comb
  begin
    phase_next = phase_reg + 2'h1;
    state_next = state_reg;
    kind_next = kind_reg;
    ir_next = ir_reg;
    pc_next = pc_reg;
    prog_addr_next = prog_addr_reg;
    taken_next = taken_reg;
    call_ok_next = call_ok_reg;
    dm_rd_next = 1'b0;
    dm_wr_next = 1'b0;
    dm_next = dm_reg;
    zero_set_next = 1'b0;
    push_next = 1'b0;
    tos_next = tos_reg;
    shadow_save_next = 1'b0;
    shadow_next = shadow_reg;
    case (phase_reg)
      PH_Q1:
      begin
        if (state_reg == ST_EXEC)
        begin
          // Decode; point the fetch path at the following word for a call.
          ir_next = i_prog_word;
          kind_next = decode_word(i_prog_word); // [RL14]
          prog_addr_next = pc_reg + PC_STEP;
        end
        else
          kind_next = K_NONE; // [RL7] [RL12]
      end
      PH_Q2:
      begin
        if (state_reg == ST_EXEC)
          pc_next = pc_reg + PC_STEP;
        case (kind_reg)
          K_BIT_TOGGLE, K_CLEAR:
          begin
            dm_rd_next = 1'b1; // [RL14]
            dm_next.addr = data_addr(ir_reg, i_ext_set_en, i_index_base, i_bank_select_reg);
          end
          K_BRANCH_OV:
            taken_next = i_status[OVF_BIT]; // [RL4]
          K_BRANCH_Z:
            taken_next = i_status[ZERO_BIT]; // [RL5]
          default:
            taken_next = 1'b0;
        endcase
      end
      PH_Q3:
      begin
        case (kind_reg)
          K_BIT_TOGGLE:
            dm_next.wdata = i_dm_rdata ^ (BIT_ONE << ir_reg[11:9]); // [RL1] [RL14]
          K_CLEAR:
            dm_next.wdata = BYTE_ZERO; // [RL13]
          K_CALL:
          begin
            // Push only when the second word really belongs to the call.
            call_ok_next = (i_prog_word[15:12] == OPC_CALL_SECOND); // [RL11]
            if (i_prog_word[15:12] == OPC_CALL_SECOND)
            begin
              push_next = 1'b1; // [RL12]
              tos_next = pc_reg + PC_STEP; // [RL8]
              if (ir_reg[8])
              begin
                shadow_save_next = 1'b1; // [RL9]
                shadow_next.working = i_working;
                shadow_next.flags = i_status;
                shadow_next.bank = i_bank_select_reg;
              end
            end
          end
          default:
            call_ok_next = 1'b0;
        endcase
      end
      PH_Q4:
      begin
        state_next = ST_EXEC;
        case (kind_reg)
          K_BIT_TOGGLE:
            dm_wr_next = 1'b1; // [RL14]
          K_CLEAR:
          begin
            dm_wr_next = 1'b1; // [RL14]
            zero_set_next = 1'b1; // [RL13]
          end
          K_BRANCH_OV, K_BRANCH_Z:
            if (taken_reg)
            begin
              pc_next = pc_reg + branch_disp; // [RL6]
              state_next = ST_IDLE; // [RL7]
            end
          K_CALL:
            if (call_ok_reg)
            begin
              pc_next = {i_prog_word[11:0], ir_reg[7:0], 1'b0}; // [RL10] [RL12]
              state_next = ST_IDLE; // [RL12]
            end
          default:
            state_next = ST_EXEC;
        endcase
        prog_addr_next = pc_next;
      end
      default:
        phase_next = PH_Q1;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      phase_reg <= PH_Q1;
      state_reg <= ST_EXEC;
      kind_reg <= K_NONE;
      ir_reg <= 16'h0000;
      pc_reg <= PC_RESET;
      prog_addr_reg <= PC_RESET;
      taken_reg <= 1'b0;
      call_ok_reg <= 1'b0;
      dm_rd_reg <= 1'b0;
      dm_wr_reg <= 1'b0;
      dm_reg <= '0;
      zero_set_reg <= 1'b0;
      push_reg <= 1'b0;
      tos_reg <= PC_RESET;
      shadow_save_reg <= 1'b0;
      shadow_reg <= '0;
    end
    else
    begin
      phase_reg <= phase_next;
      state_reg <= state_next;
      kind_reg <= kind_next;
      ir_reg <= ir_next;
      pc_reg <= pc_next;
      prog_addr_reg <= prog_addr_next;
      taken_reg <= taken_next;
      call_ok_reg <= call_ok_next;
      dm_rd_reg <= dm_rd_next;
      dm_wr_reg <= dm_wr_next;
      dm_reg <= dm_next;
      zero_set_reg <= zero_set_next;
      push_reg <= push_next;
      tos_reg <= tos_next;
      shadow_save_reg <= shadow_save_next;
      shadow_reg <= shadow_next;
    end
  end

  // The status flags are never written here except the zero flag set by clear.
  assign o_prog_addr = prog_addr_reg;
  assign o_pc = pc_reg;
  assign o_dm_rd = dm_rd_reg;
  assign o_dm_wr = dm_wr_reg;
  assign o_dm = dm_reg;
  assign o_zero_set = zero_set_reg;
  assign o_push = push_reg;
  assign o_return_stack_top = tos_reg;
  assign o_shadow_save = shadow_save_reg;
  assign o_shadow = shadow_reg;
  assign o_phase = phase_reg;
endmodule : mci_core

// ===== mci_core_chk.sv
// Checker of the core port timing.
`timescale 1ns/1ps
module mci_core_chk
  import mci_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rstn,
  // Watched outputs.
  input wire logic o_dm_rd,
  input wire logic o_dm_wr,
  input wire mci_pkg::mci_dm_req_s o_dm,
  input wire logic o_zero_set,
  input wire logic o_push,
  input wire logic o_shadow_save,
  input wire logic [mci_pkg::PC_W-1:0] o_pc,
  input wire logic [mci_pkg::PC_W-1:0] o_return_stack_top,
  input wire logic [1:0] o_phase
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_quiet;
    !o_dm_rd && !o_push && !o_shadow_save;
  endsequence
  // The second cycle of a call must leave the datapath alone.
  sequence s_idle;
    s_quiet [*4];
  endsequence
  a_phase_step: assert property ($past(i_rstn) |-> o_phase == $past(o_phase) + 2'h1)
    else $error("phase skipped");
  a_read_q3: assert property (o_dm_rd |-> o_phase == PH_Q3)
    else $error("read off Q3");
  a_write_q1: assert property (o_dm_wr |-> o_phase == PH_Q1 && $past(o_dm_rd, 2))
    else $error("write off Q1");
  a_zero_clear: assert property (o_zero_set |-> o_dm_wr && o_dm.wdata == BYTE_ZERO)
    else $error("zero set without clear");
  a_push_return: assert property (o_push |-> o_phase == PH_Q4 &&
    o_return_stack_top == o_pc + PC_STEP)
    else $error("bad return");
  a_save_push: assert property (o_shadow_save |-> o_push)
    else $error("save without call");
  a_call_idle: assert property (o_push |=> s_idle)
    else $error("call idle busy");
  a_pc_even: assert property (o_pc[0] == 1'b0)
    else $error("odd pc");
endmodule : mci_core_chk
bind mci_core mci_core_chk i_chk (.i_clk, .i_rstn, .o_dm_rd, .o_dm_wr, .o_dm, .o_zero_set,
  .o_push, .o_shadow_save, .o_pc, .o_return_stack_top, .o_phase);

// ===== mci_mem_model.sv
// Program and data memory model facing the core.
`timescale 1ns/1ps
module mci_mem_model
  import mci_pkg::*;
(
  // Clock.
  input wire logic i_clk,
  // Fetch path.
  input wire logic [mci_pkg::PC_W-1:0] i_prog_addr,
  output logic [15:0] o_prog_word,
  // Data memory.
  input wire logic i_dm_rd,
  input wire logic i_dm_wr,
  input wire mci_pkg::mci_dm_req_s i_dm,
  output logic [7:0] o_dm_rdata
);
  logic [15:0] pmem [256];
  logic [7:0] dmem [4096];
  logic [7:0] held_reg = 8'h00;
  logic rd_d_reg = 1'b0;
  initial
  begin
    for (int i = 0; i < 4096; i++)
      dmem[i] = 8'(i * 37);
    for (int i = 0; i < 256; i++)
      pmem[i] = 16'h0000;
  end
  assign o_prog_word = pmem[i_prog_addr[8:1]];
  // The cycle after a read holds the read data; later the data turn inverted, so a stale sample cannot pass for a match.
  assign o_dm_rdata = i_dm_rd ? dmem[i_dm.addr] : (rd_d_reg ? held_reg : ~held_reg);
  always @(posedge i_clk)
  begin
    rd_d_reg <= i_dm_rd;
    if (i_dm_rd)
      held_reg <= dmem[i_dm.addr];
    if (i_dm_wr)
      dmem[i_dm.addr] <= i_dm.wdata;
  end
endmodule : mci_mem_model

// ===== mci_core_bench.sv
// Random and corner bench of the instruction subset core.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD %s expected %h seen %h", n, e, g); end end
module mci_core_bench;
  import mci_pkg::*;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic ext = 1'b0;
  logic [DA_W-1:0] base = 12'h000;
  logic [3:0] bank = 4'h0;
  logic [7:0] wreg = 8'h00;
  logic [7:0] st = 8'h00;
  logic [15:0] word;
  logic [7:0] rdata;
  logic [PC_W-1:0] paddr, pc, return_stack_top;
  logic rd, wr, zs, push, save;
  logic [1:0] ph;
  mci_dm_req_s dm;
  mci_shadow_s shd;
  int checks = 0, miscompares = 0, cyc = 0, wrs = 0, zss = 0, pushes = 0, saves = 0;
  logic [31:0] seed = 32'he990;
  logic [PC_W-1:0] xpc = 21'h0;
  always #5 i_clk = ~i_clk;
  mci_core i_dut (.i_clk, .i_rstn, .i_prog_word(word), .o_prog_addr(paddr), .o_pc(pc),
    .i_ext_set_en(ext), .i_index_base(base), .i_bank_select_reg(bank), .i_working(wreg),
    .i_status(st), .i_dm_rdata(rdata), .o_dm_rd(rd), .o_dm_wr(wr), .o_dm(dm),
    .o_zero_set(zs), .o_push(push), .o_return_stack_top(return_stack_top), .o_shadow_save(save),
    .o_shadow(shd), .o_phase(ph));
  mci_mem_model i_mem (.i_clk, .i_prog_addr(paddr), .o_prog_word(word), .i_dm_rd(rd),
    .i_dm_wr(wr), .i_dm(dm), .o_dm_rdata(rdata));
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function logic [DA_W-1:0] ea(logic a, logic [7:0] f);
    if (!a && ext && f <= INDEXED_LIMIT)
      return base + DA_W'(f);
    if (!a)
      return {(f < ACCESS_SPLIT) ? ACCESS_LO_BANK : ACCESS_HI_BANK, f};
    return {bank, f};
  endfunction : ea
  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  always @(posedge i_clk)
  begin
    cyc++;
    wrs += (wr === 1'b1);
    zss += (zs === 1'b1);
    pushes += (push === 1'b1);
    saves += (save === 1'b1);
    if (cyc == 2000)
    begin
      miscompares++;
      complete_run();
    end
  end
  // Results are looked at in the last phase, where they stand settled.
  task automatic issue(logic [15:0] w1, logic [15:0] w2, logic [7:0] s, int n,
                       logic [PC_W-1:0] nxt, int mode);
    logic [31:0] r;
    logic [DA_W-1:0] a;
    r = rnd();
    i_mem.pmem[xpc[8:1]] <= w1;
    i_mem.pmem[xpc[8:1] + 8'h1] <= w2;
    st <= s;
    {ext, base, bank, wreg} <= r[24:0];
    repeat (4 * n - 1) @(posedge i_clk);
    @(negedge i_clk);
    a = ea(w1[8], w1[7:0]);
    `CHK("pc", nxt, pc)
    `CHK("fetch", nxt, paddr)
    if (mode == 1)
      `CHK("toggle", i_mem.dmem[a] ^ (8'h01 << w1[11:9]), dm.wdata)
    if (mode == 2)
      `CHK("clear", BYTE_ZERO, dm.wdata)
    if (mode != 0)
      `CHK("addr", a, dm.addr)
    @(posedge i_clk);
    xpc = nxt;
  endtask : issue
  initial
  begin
    logic [31:0] r;
    logic [7:0] f;
    logic [7:0] s;
    logic [PC_W-1:0] t;
    logic k;
    int p;
    int v;
    repeat (2) @(posedge i_clk);
    i_rstn <= 1'b1;
    for (int i = 0; i < 24; i++)
    begin
      r = rnd();
      f = (i < 4) ? INDEXED_LIMIT + i[7:0] % 8'h2 : r[7:0];
      if (i[0])
        issue({OPC_CLEAR, r[11] & (i > 3), f}, 16'h0, r[23:16], 1, xpc + PC_STEP, 2);
      else
        issue({OPC_BIT_TOGGLE, r[10:8], r[11] & (i > 3), f}, 16'h0, r[23:16], 1,
              xpc + PC_STEP, 1);
    end
    $display("register tests done");
    for (int i = 0; i < 16; i++)
    begin
      r = rnd();
      f = (i < 2) ? {~i[0], {7{i[0]}}} : r[7:0];
      k = i[2] | (i < 2);
      s = r[31:24];
      s[i[1] ? OVF_BIT : ZERO_BIT] = k;
      t = xpc + PC_STEP + (k ? {{12{f[7]}}, f, 1'b0} : 21'h0);
      issue({i[1] ? OPC_BRANCH_OV : OPC_BRANCH_Z, f}, 16'h0, s, 1 + k, t, 0);
    end
    $display("branch tests done");
    for (int i = 0; i < 6; i++)
    begin
      r = rnd();
      t = xpc;
      p = pushes;
      v = saves;
      if (i == 5)
        issue({OPC_CALL_FIRST, r[20], r[7:0]}, {4'h0, r[19:8]}, r[31:24], 1, xpc + PC_STEP,
              0);
      else
        issue({OPC_CALL_FIRST, i[0], r[7:0]}, {OPC_CALL_SECOND, r[19:8]}, r[31:24], 2,
              {r[19:0], 1'b0}, 0);
      `CHK("pushes", p + (i < 5), pushes)
      `CHK("saves", v + (i < 5 && i[0]), saves)
      if (i < 5)
        `CHK("return", t + 21'h4, return_stack_top)
      if (i < 5 && i[0])
        `CHK("shadow", {wreg, st, bank}, shd)
    end
    $display("call tests done");
    `CHK("writes", 24, wrs)
    `CHK("zero sets", 12, zss)
    complete_run();
  end
endmodule : mci_core_bench
